//--- design/tdb_drop_out.sv
// drop side output control of the shared tributary bus
`timescale 1ns/100ps
// Overview of operation
// - payload active is high for every octet of a carried tributary except the V3/H3 octet
// - negative adjustment: payload active high during the V3/H3 octet
// - positive adjustment: payload active low in the octet after V3/H3
// - flexible bandwidth: payload active high whenever a byte is available
// - payload active driven only in assigned timeslots, undriven elsewhere
// - payload indicator marks the floating payload position of each tributary
// - indicator shifts always travel with matching payload active justification
// - payload indicator driven only in assigned timeslots, else released
// - bus outputs and output active update on the rising clock edge
// - output active high exactly while any drop bus signal is driven
// - activity detect inputs used only in the slow clock configuration
// - collision when an activity detect input and own output active coincide
// - collision disables the drop drivers and raises an interrupt event
// - interrupt pulled low while unmasked source active, until acknowledged
// - fast clock select: bus driven and sampled every fourth cycle
// - drop data bus driven only in assigned timeslots
// - driven drop data carries even or odd parity over data, active, indicator
// - mistimed frame pulse floats outputs until two good pulses follow
module tdb_drop_out #(
  parameter int FRAME_TICKS = tdb_pkg::FRAME_TICKS,
  parameter int SLOTS       = tdb_pkg::SLOTS,
  parameter int FIFO_DEPTH  = tdb_pkg::FIFO_DEPTH
)(
  // clock and reset
  input  wire logic             clock_in,
  input  wire logic             reset_in,
  // configuration
  input  wire logic             fast_clock_select_in,
  input  wire logic             flex_mode_in,
  input  wire logic             parity_odd_in,
  input  wire logic [SLOTS-1:0] slot_assign_in,
  input  wire logic             collision_mask_in,
  input  wire logic             collision_ack_in,
  // tributary stream
  input  wire logic             stream_valid_in,
  output wire logic             stream_ready_out,
  input  wire logic [7:0]       stream_data_in,
  input  wire logic             stream_v5_in,
  input  wire logic             stream_v3_in,
  input  wire logic [1:0]       stream_just_in,
  // bus inputs
  input  wire logic             drop_frame_pulse_in,
  input  wire logic [1:0]       bus_activity_detect_in,
  // drop bus outputs
  output wire logic [7:0]       drop_data_bus_out,
  output wire logic             drop_data_bus_oe_out,
  output wire logic             drop_data_parity_out,
  output wire logic             drop_data_parity_oe_out,
  output wire logic             drop_payload_active_out,
  output wire logic             drop_payload_active_oe_out,
  output wire logic             drop_payload_indicator_out,
  output wire logic             drop_payload_indicator_oe_out,
  output wire logic             bus_output_active_out,
  // open-drain interrupt and status
  output wire logic             interrupt_request_n_out,
  output wire logic             interrupt_request_n_oe_out,
  output wire logic             collision_status_out
);
  localparam int CW = $clog2(FRAME_TICKS);
  localparam int SW = $clog2(SLOTS);
  localparam logic [CW-1:0] CNT_LAST  = CW'(FRAME_TICKS - 1);
  localparam logic [CW-1:0] CNT_AFTER = CW'(1);
  localparam logic [SW-1:0] SLOT_LAST = SW'(SLOTS - 1);
  localparam logic [SW-1:0] SLOT_AFTER = SW'(1);

  if (SLOTS < 2 || FRAME_TICKS < SLOTS || FIFO_DEPTH < 2) begin : g_bad_param
    $error("tdb_drop_out: need SLOTS >= 2, FRAME_TICKS >= SLOTS, FIFO_DEPTH >= 2");
  end

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (reset_in);

  tdb_fifo_if #(.WIDTH(tdb_pkg::WORD_W)) fif ();

  tdb_fifo #(
    .WIDTH (tdb_pkg::WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock_in (clock_in),
    .reset_in (reset_in),
    .f        (fif.fifo)
  );

  assign fif.wr_valid     = stream_valid_in;
  assign fif.wr_data      = {stream_just_in, stream_v3_in, stream_v5_in, stream_data_in};
  assign stream_ready_out = fif.wr_ready;

  logic [2:0]         fast_sync;
  logic               fast_mode;
  logic [1:0]         phase;
  logic               tick;
  logic [CW-1:0]      frame_cnt;
  logic [SW-1:0]      slot;
  tdb_pkg::tdb_align_t align;
  logic               pulse_ok;
  logic               pulse_bad;
  logic               collision;
  logic               collide;
  logic               drive_now;
  logic               gap_next;
  logic               take;
  logic               next_pl;
  logic               next_v5;
  logic [7:0]         next_data;
  logic               drive_q;
  logic               pl_q;
  logic               v5_q;
  logic               par_q;
  logic [7:0]         data_q;
  logic               on;
  logic [7:0]         w_data;
  logic               w_v5;
  logic               w_v3;
  logic [1:0]         w_just;

  assign w_data = fif.rd_data[tdb_pkg::W_DATA_LSB +: tdb_pkg::W_DATA_W];
  assign w_v5   = fif.rd_data[tdb_pkg::W_V5];
  assign w_v3   = fif.rd_data[tdb_pkg::W_V3];
  assign w_just = fif.rd_data[tdb_pkg::W_JUST_LSB +: tdb_pkg::W_JUST_W];

  // strap is asynchronous to the bus clock; only a settled level is taken
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      fast_sync <= tdb_pkg::SYNC_RST;
    end else begin
      fast_sync <= {fast_sync[1:0], fast_clock_select_in};
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      fast_mode <= 1'b0;
    end else if (fast_sync[1] == fast_sync[2]) begin
      fast_mode <= fast_sync[2];
    end
  end

  // bus octet timing; a mistimed pulse realigns the counters to itself
  assign tick      = !fast_mode || (phase == tdb_pkg::PHASE_RST);
  assign pulse_ok  = drop_frame_pulse_in && tick && (frame_cnt == '0);
  assign pulse_bad = drop_frame_pulse_in && !pulse_ok;

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      phase <= tdb_pkg::PHASE_RST;
    end else if (pulse_bad) begin
      phase <= tdb_pkg::PHASE_AFTER;
    end else begin
      phase <= phase + 1'b1;
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      frame_cnt <= '0;
      slot      <= '0;
    end else if (pulse_bad) begin
      frame_cnt <= CNT_AFTER;
      slot      <= SLOT_AFTER;
    end else if (tick) begin
      frame_cnt <= (frame_cnt == CNT_LAST) ? '0 : frame_cnt + 1'b1;
      slot      <= (frame_cnt == CNT_LAST || slot == SLOT_LAST) ? '0 : slot + 1'b1;
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      align <= tdb_pkg::TDB_HUNT1;
    end else if (pulse_bad) begin
      align <= tdb_pkg::TDB_HUNT1;
    end else if (pulse_ok) begin
      case (align)
        tdb_pkg::TDB_HUNT1:  align <= tdb_pkg::TDB_HUNT2;
        tdb_pkg::TDB_HUNT2:  align <= tdb_pkg::TDB_LOCKED;
        tdb_pkg::TDB_LOCKED: align <= tdb_pkg::TDB_LOCKED;
        default:             align <= tdb_pkg::TDB_HUNT1;
      endcase
    end
  end

  assign drive_now = (align == tdb_pkg::TDB_LOCKED) && slot_assign_in[slot] && !collision;

  // octet selection; gap octet after a positive adjustment consumes nothing
  always_comb begin
    next_pl   = 1'b0;
    next_v5   = 1'b0;
    next_data = tdb_pkg::DATA_RST;
    take      = 1'b0;
    if (drive_now) begin
      if (flex_mode_in) begin
        next_pl   = fif.rd_valid;
        take      = fif.rd_valid;
        next_v5   = fif.rd_valid & w_v5;
        next_data = w_data;
      end else if (gap_next) begin
        next_pl = 1'b0;
      end else if (fif.rd_valid) begin
        take      = 1'b1;
        next_data = w_data;
        next_v5   = w_v5;
        if (w_v3) begin
          next_pl = (w_just == tdb_pkg::JUST_NEG);
        end else begin
          next_pl = 1'b1;
        end
      end
    end
  end

  assign fif.rd_ready = tick && take;

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      gap_next <= 1'b0;
    end else if (tick && take && !flex_mode_in && w_v3 && w_just == tdb_pkg::JUST_POS) begin
      gap_next <= 1'b1;
    end else if (tick && drive_now && !flex_mode_in) begin
      gap_next <= 1'b0;
    end
  end

  // outputs change only on bus octet boundaries, except that a mistimed pulse clears drive_q at once
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      drive_q <= 1'b0;
      pl_q    <= 1'b0;
      v5_q    <= 1'b0;
      par_q   <= 1'b0;
      data_q  <= tdb_pkg::DATA_RST;
    end else if (pulse_bad) begin
      drive_q <= 1'b0;
    end else if (tick) begin
      drive_q <= drive_now;
      pl_q    <= next_pl;
      v5_q    <= next_v5;
      data_q  <= next_data;
      par_q   <= (^{next_data, next_pl, next_v5}) ^ parity_odd_in;
    end
  end

  // collision cuts the drivers at the next clock edge, without waiting for drive_q to follow at a later octet boundary
  assign on = drive_q && !collision;

  assign drop_data_bus_out             = data_q;
  assign drop_data_bus_oe_out          = on;
  assign drop_data_parity_out          = par_q;
  assign drop_data_parity_oe_out       = on;
  assign drop_payload_active_out       = pl_q;
  assign drop_payload_active_oe_out    = on;
  assign drop_payload_indicator_out    = v5_q;
  assign drop_payload_indicator_oe_out = on;
  assign bus_output_active_out         = on;

  // neighbours' activity lines are meaningless at the fast rate
  assign collide = !fast_mode && (|bus_activity_detect_in) && on;

  // a new collision in the acknowledge cycle keeps the flag set
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      collision <= 1'b0;
    end else if (collide) begin
      collision <= 1'b1;
    end else if (collision_ack_in) begin
      collision <= 1'b0;
    end
  end

  assign interrupt_request_n_out    = 1'b0;
  assign interrupt_request_n_oe_out = collision && !collision_mask_in;
  assign collision_status_out       = collision;

  logic tick_q;

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= tick;
    end
  end

  property p_act_match;
    bus_output_active_out == drop_data_bus_oe_out &&
    bus_output_active_out == drop_payload_indicator_oe_out;
  endproperty
  a_act_match: assert property (p_act_match)
    else $error("output active differs from drive enables");

  property p_collide_cut;
    collide |=> !drop_data_bus_oe_out && !bus_output_active_out;
  endproperty
  a_collide_cut: assert property (p_collide_cut)
    else $error("drivers still on after collision");

  property p_collide_flag;
    collide |=> collision_status_out;
  endproperty
  a_collide_flag: assert property (p_collide_flag)
    else $error("collision not flagged");

  property p_collision_hold;
    collision_status_out && !collision_ack_in |=> collision_status_out && !bus_output_active_out;
  endproperty
  a_collision_hold: assert property (p_collision_hold)
    else $error("collision cleared or output active without acknowledge");

  property p_irq_low;
    collision_status_out && !collision_mask_in |-> interrupt_request_n_oe_out
      && !interrupt_request_n_out;
  endproperty
  a_irq_low: assert property (p_irq_low)
    else $error("interrupt not pulled low for unmasked collision");

  property p_parity;
    drop_data_bus_oe_out |-> drop_data_parity_out == ((^{drop_data_bus_out,
      drop_payload_active_out, drop_payload_indicator_out}) ^ parity_odd_in);
  endproperty
  a_parity: assert property (p_parity)
    else $error("drop parity wrong");

  property p_neg_adjust;
    tick && take && !flex_mode_in && w_v3 && w_just == tdb_pkg::JUST_NEG
      |=> drop_payload_active_out;
  endproperty
  a_neg_adjust: assert property (p_neg_adjust)
    else $error("payload active low on negative adjustment octet");

  property p_fast_hold;
    fast_mode && !tick_q |-> $stable(drop_data_bus_out);
  endproperty
  a_fast_hold: assert property (p_fast_hold)
    else $error("drop data changed between fast octet boundaries");

  property p_bad_pulse;
    pulse_bad |=> !drop_data_bus_oe_out [*4];
  endproperty
  a_bad_pulse: assert property (p_bad_pulse)
    else $error("drivers on after mistimed frame pulse");

  property p_only_locked;
    drop_payload_active_oe_out |-> align == tdb_pkg::TDB_LOCKED;
  endproperty
  a_only_locked: assert property (p_only_locked)
    else $error("driving while frame alignment not confirmed");

  c_locked: cover property (align == tdb_pkg::TDB_LOCKED && drop_data_bus_oe_out);
  c_collision: cover property (collide ##1 collision_status_out);
  c_pos_gap: cover property (gap_next && tick && drive_now);
  c_flex: cover property (flex_mode_in && fif.rd_ready && fif.rd_valid);
endmodule

//--- design/tdb_fifo.sv
// stream buffer with a registered head word
`timescale 1ns/100ps
module tdb_fifo #(
  parameter int WIDTH = tdb_pkg::WORD_W,
  parameter int DEPTH = tdb_pkg::FIFO_DEPTH
)(
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // both sides
  tdb_fifo_if.fifo f
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("tdb_fifo: DEPTH must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wptr;
  logic [AW-1:0]    rptr;
  logic [AW:0]      count;
  logic [WIDTH-1:0] head;
  logic             head_v;
  logic             push;
  logic             pop_out;
  logic             load;

  assign push       = f.wr_valid & f.wr_ready;
  assign pop_out    = f.rd_valid & f.rd_ready;
  // head refills from memory whenever it is free or being taken
  assign load       = (count != '0) & (~head_v | pop_out);
  assign f.wr_ready = (count != (AW + 1)'(DEPTH));
  assign f.rd_valid = head_v;
  assign f.rd_data  = head;

  always_ff @(posedge clock_in) begin
    if (push) begin
      mem[wptr] <= f.wr_data;
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      wptr <= '0;
    end else if (push) begin
      wptr <= wptr + 1'b1;
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      rptr <= '0;
      head <= '0;
    end else if (load) begin
      rptr <= rptr + 1'b1;
      head <= mem[rptr];
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      head_v <= 1'b0;
    end else if (load) begin
      head_v <= 1'b1;
    end else if (pop_out) begin
      head_v <= 1'b0;
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      count <= '0;
    end else if (push && !load) begin
      count <= count + 1'b1;
    end else if (!push && load) begin
      count <= count - 1'b1;
    end
  end
endmodule

//--- shared/tdb_fifo_if.sv
// valid/ready carrier between the stream buffer and the bus logic
`timescale 1ns/100ps
interface tdb_fifo_if #(
  parameter int WIDTH = tdb_pkg::WORD_W
);
  logic             wr_valid;
  logic             wr_ready;
  logic [WIDTH-1:0] wr_data;
  logic             rd_valid;
  logic             rd_ready;
  logic [WIDTH-1:0] rd_data;

  modport fifo (
    input  wr_valid,
    input  wr_data,
    input  rd_ready,
    output wr_ready,
    output rd_valid,
    output rd_data
  );

  modport user (
    output wr_valid,
    output wr_data,
    output rd_ready,
    input  wr_ready,
    input  rd_valid,
    input  rd_data
  );
endinterface

//--- shared/tdb_pkg.sv
// shared constants and types for the drop bus output block
package tdb_pkg;
  // bus structure
  localparam int FRAME_TICKS = 9720;
  localparam int SLOTS       = 84;
  localparam int FAST_DIV    = 4;
  localparam int FIFO_DEPTH  = 8;

  // tributary word layout
  localparam int W_DATA_LSB = 0;
  localparam int W_DATA_W   = 8;
  localparam int W_V5       = 8;
  localparam int W_V3       = 9;
  localparam int W_JUST_LSB = 10;
  localparam int W_JUST_W   = 2;
  localparam int WORD_W     = 12;

  // justification request carried with the V3/H3 octet
  localparam logic [1:0] JUST_NONE = 2'h0;
  localparam logic [1:0] JUST_NEG  = 2'h1;
  localparam logic [1:0] JUST_POS  = 2'h2;

  // reset and realign values
  localparam logic [1:0] PHASE_RST   = 2'h0;
  localparam logic [1:0] PHASE_AFTER = 2'h1;
  localparam logic [2:0] SYNC_RST    = 3'h0;
  localparam logic [7:0] DATA_RST    = 8'h00;

  typedef enum logic [1:0] {
    TDB_HUNT1,
    TDB_HUNT2,
    TDB_LOCKED
  } tdb_align_t;
endpackage

//--- tb/tdb_partner.sv
// far-end model: frame pulse source, neighbour activity lines, bus line view
`timescale 1ns/100ps
module tdb_partner #(
  parameter int FT = 200
)(
  // clock and reset
  input  wire logic       clock_in,
  input  wire logic       reset_in,
  // rate select, as strapped on the block
  input  wire logic       fast_in,
  // drop bus as driven by the block
  input  wire logic [7:0] data_in,
  input  wire logic [2:0] oe_in,
  input  wire logic       pa_in,
  input  wire logic       ind_in,
  // far-end drive
  output logic            fp_out,
  output logic [1:0]      det_out,
  // resolved bus lines
  output wire logic [7:0] data_out,
  output wire logic       pa_out,
  output wire logic       ind_out
);
  logic [15:0] cnt;
  logic        bad;
  logic [9:0]  last;

  // a frame spans the same number of octets at either rate
  localparam logic [15:0] SLOW_LAST = 16'(FT - 1);
  localparam logic [15:0] FAST_LAST = 16'(tdb_pkg::FAST_DIV * FT - 1);

  // released lines toggle so a stale value can never pass for a driven one
  assign data_out = oe_in[0] ? data_in : ~last[7:0];
  assign pa_out   = oe_in[1] ? pa_in : ~last[8];
  assign ind_out  = oe_in[2] ? ind_in : ~last[9];

  initial begin
    bad = 1'b0;
    last = 10'h000;
    det_out = 2'h0;
  end

  always @(posedge clock_in) last <= {ind_out, pa_out, data_out};

  always @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      cnt <= 16'h0000;
      fp_out <= 1'b0;
    end else if (bad || cnt == (fast_in ? FAST_LAST : SLOW_LAST)) begin
      cnt <= 16'h0000;
      fp_out <= 1'b1;
    end else begin
      cnt <= cnt + 16'h0001;
      fp_out <= 1'b0;
    end
  end

  // keep clear of the frame boundary so the pulse is surely off-time
  task automatic bad_pulse();
    while (cnt < 16'h000A || cnt > 16'(FT - 10)) @(posedge clock_in);
    bad <= 1'b1;
    @(posedge clock_in);
    bad <= 1'b0;
  endtask

  task automatic detect(input logic [1:0] b);
    det_out <= b;
    @(posedge clock_in);
    det_out <= 2'h0;
  endtask
endmodule

//--- tb/tributary_drop_bus_output_bench.sv
// self-checking bench for the drop bus output block
`timescale 1ns/100ps
module tributary_drop_bus_output_bench;
  localparam int FT = 200;
  localparam int SL = 4;
  logic          clock_in, reset_in, flex, odd, mask, ack;
  logic          s_valid, s_v5, s_v3, fp, chk_en, gap_on, exp_oe, fast;
  logic [1:0]    s_just, det;
  logic [7:0]    s_data, d_out, w_data;
  logic [SL-1:0] slots;
  logic          s_ready, par, pa, ind, bao, irq_n, irq_oe, coll;
  logic          d_oe, par_oe, pa_oe, ind_oe, w_pa, w_ind;
  logic [8:0]    q[$];
  int            fail_count, samples_checked, gaps, s_cur, seed, sub;
  wire           irq_line = irq_oe ? irq_n : 1'b1;

  always #50 clock_in = ~clock_in;

  tdb_drop_out #(.FRAME_TICKS(FT), .SLOTS(SL), .FIFO_DEPTH(8)) tdb_drop_out_inst (
    .clock_in(clock_in), .reset_in(reset_in), .fast_clock_select_in(fast),
    .flex_mode_in(flex), .parity_odd_in(odd), .slot_assign_in(slots),
    .collision_mask_in(mask), .collision_ack_in(ack), .stream_valid_in(s_valid),
    .stream_ready_out(s_ready), .stream_data_in(s_data), .stream_v5_in(s_v5),
    .stream_v3_in(s_v3), .stream_just_in(s_just), .drop_frame_pulse_in(fp),
    .bus_activity_detect_in(det), .drop_data_bus_out(d_out),
    .drop_data_bus_oe_out(d_oe), .drop_data_parity_out(par),
    .drop_data_parity_oe_out(par_oe), .drop_payload_active_out(pa),
    .drop_payload_active_oe_out(pa_oe), .drop_payload_indicator_out(ind),
    .drop_payload_indicator_oe_out(ind_oe), .bus_output_active_out(bao),
    .interrupt_request_n_out(irq_n), .interrupt_request_n_oe_out(irq_oe),
    .collision_status_out(coll));

  tdb_partner #(.FT(FT)) tdb_partner_inst (
    .clock_in(clock_in), .reset_in(reset_in), .fast_in(fast), .data_in(d_out),
    .oe_in({ind_oe, pa_oe, d_oe}), .pa_in(pa), .ind_in(ind), .fp_out(fp),
    .det_out(det), .data_out(w_data), .pa_out(w_pa), .ind_out(w_ind));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  task automatic end_sim();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // on_q: wait for the note queue to empty, else for the block to drive
  task automatic wait_for(input bit on_q, input int lim);
    int n;
    n = 0;
    while ((on_q ? q.size() != 0 : bao !== 1'b1) && n < lim) begin
      @(negedge clock_in);
      n++;
    end
    if (n >= lim) begin
      check(0, 1, "wait timeout");
      end_sim();
    end
    @(posedge clock_in);
  endtask

  task automatic push(input logic [11:0] w, input int tries, output bit ok);
    @(posedge clock_in);
    {s_just, s_v3, s_v5, s_data} <= w;
    s_valid <= 1'b1;
    ok = 0;
    for (int i = 0; i < tries && !ok; i++) begin
      @(negedge clock_in);
      ok = s_ready;
      @(posedge clock_in);
    end
    s_valid <= 1'b0;
    // only a negative adjustment makes the adjustment octet carry a byte
    if (ok && !(w[9] && w[11:10] !== tdb_pkg::JUST_NEG)) q.push_back(w[8:0]);
  endtask

  // slot of the tick that ends at this edge; at the fast rate one edge in four
  always @(posedge clock_in) begin
    sub = (fp || !fast) ? 0 : (sub + 1) % tdb_pkg::FAST_DIV;
    if (sub == 0) begin
      s_cur = fp ? 0 : (s_cur + 1) % SL;
      exp_oe = slots[s_cur];
    end
  end

  always @(negedge clock_in) if (!reset_in) begin
    check(bao, &{d_oe, par_oe, pa_oe, ind_oe}, "active flag");
    if (d_oe) check(par, ^{w_data, w_pa, w_ind, odd}, "parity");
    // each octet is looked at once, in its first cycle
    if (sub == 0) begin
      if (chk_en) check({d_oe, pa_oe, ind_oe}, {3{exp_oe}}, "slot drive");
      if (pa_oe && w_pa) begin
        if (q.size() == 0) check(1, 0, "extra octet");
        else check({w_ind, w_data}, q.pop_front(), "octet");
      end else if (pa_oe && gap_on && q.size() != 0) gaps++;
    end
  end

  initial begin
    logic [31:0] r;
    logic [11:0] w;
    bit          ok;
    seed = 32'h2CC1F0A9;
    {clock_in, flex, odd, mask, ack, s_valid, s_v5, s_v3, chk_en, gap_on, fast} = '0;
    {s_just, s_data} = '0;
    slots = 4'h5;
    reset_in = 1'b1;
    repeat (11) @(posedge clock_in);
    @(negedge clock_in);
    check({d_oe, par_oe, pa_oe, ind_oe, bao, irq_oe, coll, s_ready}, 8'h01, "reset");
    @(posedge clock_in);
    reset_in <= 1'b0;
    wait_for(0, 2000);
    chk_en = 1'b1;
    $display("test lock done");
    for (int i = 0; i < 12; i++) begin
      r = $random(seed);
      push({3'h0, r[8:0]}, 20, ok);
      check(ok, 1, "push");
      repeat (r[13:12]) @(posedge clock_in);
    end
    wait_for(1, 500);
    $display("test stream done");
    // far side stalls: no slots, buffer must fill and then refuse
    slots <= 4'h0;
    repeat (3) @(posedge clock_in);
    odd <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      r = $random(seed);
      w = r[11:0];
      w[9] = (i == 1 || i == 3 || i == 5);
      if (i == 1) w[11:10] = tdb_pkg::JUST_NONE;
      if (i == 3) w[11:10] = tdb_pkg::JUST_POS;
      if (i == 5) w[11:10] = tdb_pkg::JUST_NEG;
      push(w, i < 9 ? 1 : 3, ok);
      check(ok, i < 9, "fill");
    end
    gaps = 0;
    gap_on = 1'b1;
    slots <= 4'h5;
    wait_for(1, 500);
    gap_on = 1'b0;
    check(gaps, 3, "adjust gaps");
    $display("test fill and adjust done");
    flex <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      push({3'h0, r[8:0]}, 20, ok);
    end
    wait_for(1, 500);
    flex <= 1'b0;
    $display("test flex done");
    chk_en = 1'b0;
    slots <= 4'hF;
    for (int i = 0; i < 2; i++) begin
      @(posedge clock_in);
      mask <= i[0];
      wait_for(0, 100);
      tdb_partner_inst.detect(i[0] ? 2'h2 : 2'h1);
      @(negedge clock_in);
      check({coll, bao, irq_line}, {2'b10, i[0]}, "collision");
      repeat (8) begin
        @(negedge clock_in);
        check({coll, bao}, 2'b10, "held off");
      end
      @(posedge clock_in);
      ack <= 1'b1;
      @(posedge clock_in);
      ack <= 1'b0;
      @(negedge clock_in);
      check({coll, irq_line}, 2'b01, "acknowledged");
    end
    wait_for(0, 100);
    chk_en = 1'b1;
    repeat (SL * 2) @(posedge clock_in);
    $display("test collision done");
    chk_en = 1'b0;
    tdb_partner_inst.bad_pulse();
    repeat (2) @(posedge clock_in);
    repeat (2 * FT - 4) begin
      @(negedge clock_in);
      check(bao, 0, "realign float");
    end
    wait_for(0, 2 * FT);
    chk_en = 1'b1;
    repeat (SL * 4) @(posedge clock_in);
    $display("test realign done");
    // fast rate: octets every fourth cycle, neighbour lines ignored
    chk_en = 1'b0;
    fast <= 1'b1;
    slots <= 4'h9;
    repeat (tdb_pkg::FAST_DIV * FT + 8) @(posedge clock_in);
    wait_for(0, 3 * tdb_pkg::FAST_DIV * FT);
    chk_en = 1'b1;
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      push({3'h0, r[8:0]}, 20, ok);
      check(ok, 1, "fast push");
    end
    wait_for(1, 500);
    chk_en = 1'b0;
    slots <= 4'hF;
    repeat (tdb_pkg::FAST_DIV * SL) @(posedge clock_in);
    tdb_partner_inst.detect(2'h3);
    repeat (2) @(negedge clock_in);
    check({coll, bao, irq_line}, 3'b011, "fast detect ignored");
    $display("test fast rate done");
    end_sim();
  end
endmodule
